// [core/adc_serial_control_byte_frontend.sv]
`timescale 1ns/1ps
module adc_serial_control_byte_frontend #(
  parameter int RESULT_BITS = adc_frontend_pkg::RESULT_LEN,
  parameter int MAX_CONV_CYCLES = adc_frontend_pkg::MAX_CONV_CYCLES
) (
  input logic core_clk_in,
  input logic rst_in,
  input logic sclk_in,
  input logic cs_n_in,
  input logic din_in,
  input logic comparator_in,
  output logic dout_out,
  output logic dout_oe_out,
  output logic strobe_out,
  output logic strobe_oe_out,
  output logic track_out,
  output logic hold_out,
  output adc_frontend_pkg::route_t route_out,
  output logic [RESULT_BITS-1:0] dac_trial_out,
  output adc_frontend_pkg::cmd_t result_cmd_out,
  output logic [RESULT_BITS-1:0] result_out,
  output logic result_valid_out,
  output logic busy_out,
  output logic overtime_out
);

  // ============================================================
  // Elaboration checks
  if (RESULT_BITS < 2 || RESULT_BITS > 15) begin : g_bad_bits
    $error("RESULT_BITS must lie in 2..15");
  end
  if (MAX_CONV_CYCLES < 1) begin : g_bad_cycles
    $error("MAX_CONV_CYCLES must be at least 1");
  end

  localparam logic [RESULT_BITS-1:0] MASK_MSB = {1'h1, {(RESULT_BITS-1){1'h0}}};
  localparam logic [RESULT_BITS-1:0] CODE_ZERO = {RESULT_BITS{1'h0}};
  localparam logic [3:0] CONV_CNT_LAST = 4'(RESULT_BITS - 1);

  // ============================================================
  // Channel routing decode
  function automatic adc_frontend_pkg::route_t decode_route(input adc_frontend_pkg::cmd_t c);
    adc_frontend_pkg::route_t r;
    logic [2:0] sel;
    r = adc_frontend_pkg::ROUTE_RESET;
    sel = {c.chan_sel_hi, c.chan_sel_mid, c.chan_sel_lo};
    if (c.input_config_mode) begin
      // Single ended: positive channel against the common input
      r.neg_common = 1'h1;
      case (sel)
        adc_frontend_pkg::SEL_CH0: r.pos = adc_frontend_pkg::CH0_ON;
        adc_frontend_pkg::SEL_CH1: r.pos = adc_frontend_pkg::CH1_ON;
        adc_frontend_pkg::SEL_CH2: r.pos = adc_frontend_pkg::CH2_ON;
        adc_frontend_pkg::SEL_CH3: r.pos = adc_frontend_pkg::CH3_ON;
        default: r.pos = adc_frontend_pkg::CH_NONE;
      endcase
    end else begin
      // Differential: negative node goes to the pair mate
      case (sel)
        adc_frontend_pkg::SEL_CH0: begin
          r.pos = adc_frontend_pkg::CH0_ON;
          r.neg = adc_frontend_pkg::CH1_ON;
        end
        adc_frontend_pkg::SEL_CH1: begin
          r.pos = adc_frontend_pkg::CH1_ON;
          r.neg = adc_frontend_pkg::CH0_ON;
        end
        adc_frontend_pkg::SEL_CH2: begin
          r.pos = adc_frontend_pkg::CH2_ON;
          r.neg = adc_frontend_pkg::CH3_ON;
        end
        adc_frontend_pkg::SEL_CH3: begin
          r.pos = adc_frontend_pkg::CH3_ON;
          r.neg = adc_frontend_pkg::CH2_ON;
        end
        default: begin
          // Unlisted codes leave every switch open
          r.pos = adc_frontend_pkg::CH_NONE;
          r.neg = adc_frontend_pkg::CH_NONE;
        end
      endcase
    end
    return r;
  endfunction

  // ============================================================
  // Link reset: select high clears all framing at once
  logic link_rst;
  assign link_rst = rst_in | cs_n_in;

  // Outputs released while deselected
  assign dout_oe_out = ~cs_n_in;
  assign strobe_oe_out = ~cs_n_in;

  // ============================================================
  // Rising edge side: command byte capture
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [adc_frontend_pkg::CMD_LEN-1:0] shreg;
  logic start_ok;
  logic byte_start;
  logic byte_busy;
  logic shift_en;

  // Zeros pass unseen until a one arrives while a start is allowed
  assign byte_busy = (bit_cnt != adc_frontend_pkg::BIT_CNT_IDLE);
  assign byte_start = ~byte_busy & din_in & start_ok;
  assign shift_en = byte_start | (byte_busy & (bit_cnt != adc_frontend_pkg::BIT_CNT_LAST));
  assign next_bit_cnt = byte_start ? adc_frontend_pkg::BIT_CNT_FIRST :
                        (bit_cnt == adc_frontend_pkg::BIT_CNT_LAST) ? adc_frontend_pkg::BIT_CNT_IDLE :
                        byte_busy ? 4'(bit_cnt + 4'h1) : adc_frontend_pkg::BIT_CNT_IDLE;

  // Bit counter and shift register
  always_ff @(posedge sclk_in or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt <= adc_frontend_pkg::BIT_CNT_IDLE;
      shreg <= adc_frontend_pkg::CMD_RESET;
    end else begin
      bit_cnt <= next_bit_cnt;
      if (shift_en) begin
        shreg <= {shreg[adc_frontend_pkg::CMD_LEN-2:0], din_in};
      end
    end
  end

  // ============================================================
  // Falling edge side: track, hold and successive approximation
  adc_frontend_pkg::link_state_t state;
  adc_frontend_pkg::link_state_t next_state;
  adc_frontend_pkg::cmd_t cmd;
  adc_frontend_pkg::cmd_t next_cmd;
  adc_frontend_pkg::cmd_t shreg_cmd;
  adc_frontend_pkg::route_t next_route;
  logic next_track;
  logic next_hold;
  logic next_strobe;
  logic next_dout;
  logic [3:0] conv_cnt;
  logic [3:0] next_conv_cnt;
  logic [RESULT_BITS-1:0] code;
  logic [RESULT_BITS-1:0] next_code;
  logic [RESULT_BITS-1:0] mask;
  logic [RESULT_BITS-1:0] next_mask;
  logic [RESULT_BITS-1:0] code_kept;
  logic conv_last;
  logic out_bit;
  logic byte_done;
  logic shreg_ext;

  assign shreg_cmd = adc_frontend_pkg::cmd_t'(shreg);
  assign byte_done = (bit_cnt == adc_frontend_pkg::BIT_CNT_LAST);
  assign shreg_ext = ({shreg_cmd.power_clock_mode_hi, shreg_cmd.power_clock_mode_lo}
                      == adc_frontend_pkg::MODE_EXT_CLK);
  assign conv_last = (conv_cnt == CONV_CNT_LAST);
  // Comparator high means the input sits above the trial level
  assign code_kept = comparator_in ? (code | mask) : code;
  // Bipolar flips the first decision to give twos complement
  assign out_bit = (conv_cnt == adc_frontend_pkg::CONV_CNT_RESET) & ~cmd.polarity_mode ?
                   ~comparator_in : comparator_in;
  // A new start waits until five result bits have left
  assign start_ok = (state == adc_frontend_pkg::ST_IDLE) | (state == adc_frontend_pkg::ST_TAIL) |
                    ((state == adc_frontend_pkg::ST_CONV) & (conv_cnt >= adc_frontend_pkg::START_OK_CNT));

  // Next-state decode for the falling edge
  always_comb begin
    next_state = state;
    next_cmd = cmd;
    next_route = route_out;
    next_track = track_out;
    next_hold = hold_out;
    next_strobe = 1'h0;
    next_dout = dout_out;
    next_conv_cnt = conv_cnt;
    next_code = code;
    next_mask = mask;
    if (byte_done) begin
      // Whole byte in: latch fields and open the sampling switch
      next_cmd = shreg_cmd;
      next_route = decode_route(shreg_cmd);
      next_track = 1'h0;
      next_dout = 1'h0;
      next_conv_cnt = adc_frontend_pkg::CONV_CNT_RESET;
      next_code = CODE_ZERO;
      next_mask = MASK_MSB;
      if (shreg_ext) begin
        next_state = adc_frontend_pkg::ST_CONV;
        next_hold = 1'h1;
        next_strobe = 1'h1;
      end else begin
        // Internal clock and power-down modes only take the settings
        next_state = adc_frontend_pkg::ST_IDLE;
        next_hold = 1'h0;
      end
    end else if (bit_cnt == adc_frontend_pkg::BIT_CNT_TRACK) begin
      next_state = adc_frontend_pkg::ST_TRACK;
      next_track = 1'h1;
      next_hold = 1'h0;
      next_dout = 1'h0;
    end else begin
      case (state)
        adc_frontend_pkg::ST_CONV: begin
          // One decision per falling edge, shown at once
          next_dout = out_bit;
          next_code = code_kept;
          next_mask = mask >> 1;
          next_conv_cnt = 4'(conv_cnt + 4'h1);
          if (conv_last) begin
            next_state = adc_frontend_pkg::ST_TAIL;
            next_hold = 1'h0;
          end
        end
        adc_frontend_pkg::ST_TAIL: begin
          next_dout = 1'h0;
        end
        adc_frontend_pkg::ST_IDLE: begin
          next_dout = 1'h0;
        end
        adc_frontend_pkg::ST_TRACK: begin
          next_dout = 1'h0;
        end
        default: begin
          next_state = adc_frontend_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Falling edge registers
  always_ff @(negedge sclk_in or posedge link_rst) begin
    if (link_rst) begin
      state <= adc_frontend_pkg::ST_IDLE;
      cmd <= adc_frontend_pkg::CMD_RESET;
      route_out <= adc_frontend_pkg::ROUTE_RESET;
      track_out <= 1'h0;
      hold_out <= 1'h0;
      strobe_out <= 1'h0;
      dout_out <= 1'h0;
      conv_cnt <= adc_frontend_pkg::CONV_CNT_RESET;
      code <= CODE_ZERO;
      mask <= CODE_ZERO;
      dac_trial_out <= CODE_ZERO;
    end else begin
      state <= next_state;
      cmd <= next_cmd;
      route_out <= next_route;
      track_out <= next_track;
      hold_out <= next_hold;
      strobe_out <= next_strobe;
      dout_out <= next_dout;
      conv_cnt <= next_conv_cnt;
      code <= next_code;
      mask <= next_mask;
      dac_trial_out <= next_code | next_mask;
    end
  end

  // ============================================================
  // Finished word, kept through deselect for the core side
  logic conv_done;
  logic [RESULT_BITS-1:0] done_word;
  logic [RESULT_BITS-1:0] link_word;
  adc_frontend_pkg::cmd_t link_cmd;
  logic link_toggle;

  assign conv_done = (state == adc_frontend_pkg::ST_CONV) & conv_last & ~byte_done;
  assign done_word = {code_kept[RESULT_BITS-1] ^ ~cmd.polarity_mode, code_kept[RESULT_BITS-2:0]};

  // Only power reset clears these, so select cannot fake a toggle
  always_ff @(negedge sclk_in or posedge rst_in) begin
    if (rst_in) begin
      link_word <= CODE_ZERO;
      link_cmd <= adc_frontend_pkg::CMD_RESET;
      link_toggle <= 1'h0;
    end else if (conv_done) begin
      link_word <= done_word;
      link_cmd <= cmd;
      link_toggle <= ~link_toggle;
    end
  end

  // ============================================================
  // Core clock side: toggle and busy crossings
  logic tog_sync1;
  logic tog_sync2;
  logic tog_seen;
  logic busy_sync1;
  logic busy_link;
  logic [31:0] busy_cnt;
  logic take_word;

  // Busy leaves a flop, so no decode glitch reaches the synchroniser
  always_ff @(negedge sclk_in or posedge link_rst) begin
    if (link_rst) begin
      busy_link <= 1'h0;
    end else begin
      busy_link <= (next_state == adc_frontend_pkg::ST_CONV);
    end
  end

  // Word is stable long before its toggle lands here
  assign take_word = tog_sync2 ^ tog_seen;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tog_sync1 <= 1'h0;
      tog_sync2 <= 1'h0;
      tog_seen <= 1'h0;
      busy_sync1 <= 1'h0;
      busy_out <= 1'h0;
    end else begin
      tog_sync1 <= link_toggle;
      tog_sync2 <= tog_sync1;
      tog_seen <= tog_sync2;
      busy_sync1 <= busy_link;
      busy_out <= busy_sync1;
    end
  end

  // Result capture on each new word
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      result_out <= CODE_ZERO;
      result_cmd_out <= adc_frontend_pkg::CMD_RESET;
      result_valid_out <= 1'h0;
    end else begin
      result_valid_out <= take_word;
      if (take_word) begin
        result_out <= link_word;
        result_cmd_out <= link_cmd;
      end
    end
  end

  // Droop watch: flags a conversion stretched by clock gaps
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_cnt <= 32'h0000_0000;
      overtime_out <= 1'h0;
    end else if (!busy_out) begin
      busy_cnt <= 32'h0000_0000;
      overtime_out <= 1'h0;
    end else begin
      if (busy_cnt != 32'hFFFF_FFFF) begin
        busy_cnt <= busy_cnt + 32'h0000_0001;
      end
      overtime_out <= (busy_cnt >= 32'(MAX_CONV_CYCLES));
    end
  end

  // ============================================================
  // Checks on the link logic
  AST_TRACK_AFTER_FIFTH: assert property (
    @(negedge sclk_in) disable iff (link_rst)
    (bit_cnt == adc_frontend_pkg::BIT_CNT_TRACK) |=> (track_out && !hold_out))
    else $error("track not entered after fifth bit");

  AST_HOLD_AFTER_EIGHTH: assert property (
    @(negedge sclk_in) disable iff (link_rst)
    (byte_done && shreg_ext) |=> (hold_out && !track_out && strobe_out))
    else $error("hold not entered after eighth bit");

  AST_SINGLE_ENDED_ROUTE: assert property (
    @(negedge sclk_in) disable iff (link_rst)
    (cmd.input_config_mode && {cmd.chan_sel_hi, cmd.chan_sel_mid, cmd.chan_sel_lo} == adc_frontend_pkg::SEL_CH1)
    |-> (route_out.neg_common && route_out.pos == adc_frontend_pkg::CH1_ON
         && route_out.neg == adc_frontend_pkg::CH_NONE))
    else $error("single ended routing wrong");

  AST_DIFF_ROUTE: assert property (
    @(negedge sclk_in) disable iff (link_rst)
    (!cmd.input_config_mode && {cmd.chan_sel_hi, cmd.chan_sel_mid, cmd.chan_sel_lo} == adc_frontend_pkg::SEL_CH3)
    |-> (!route_out.neg_common && route_out.pos == adc_frontend_pkg::CH3_ON
         && route_out.neg == adc_frontend_pkg::CH2_ON))
    else $error("differential routing wrong");

  AST_ZEROS_IGNORED: assert property (
    @(posedge sclk_in) disable iff (link_rst)
    (!byte_busy && !din_in) |=> (bit_cnt == adc_frontend_pkg::BIT_CNT_IDLE))
    else $error("zero bit started a byte");

  AST_SHIFT_IN: assert property (
    @(posedge sclk_in) disable iff (link_rst)
    shift_en |=> (shreg[0] == $past(din_in)))
    else $error("input bit not shifted in");

  AST_FIELDS_LATCHED: assert property (
    @(negedge sclk_in) disable iff (link_rst)
    byte_done |=> (cmd == $past(shreg)))
    else $error("command fields not latched");

  AST_STROBE_ONE_CLOCK: assert property (
    @(negedge sclk_in) disable iff (link_rst)
    strobe_out |-> (hold_out && !dout_out) ##1 !strobe_out)
    else $error("strobe not a single clock");

  AST_TWELVE_DECISIONS: assert property (
    @(negedge sclk_in) disable iff (link_rst)
    (byte_done && shreg_ext) |=> (state == adc_frontend_pkg::ST_CONV) ##12 (state == adc_frontend_pkg::ST_TAIL))
    else $error("conversion length wrong");

  AST_TAIL_ZEROS: assert property (
    @(negedge sclk_in) disable iff (link_rst)
    (state == adc_frontend_pkg::ST_TAIL && $past(state) == adc_frontend_pkg::ST_TAIL) |-> !dout_out)
    else $error("padding bit not zero");

  AST_BIPOLAR_MSB: assert property (
    @(negedge sclk_in) disable iff (link_rst)
    (state == adc_frontend_pkg::ST_CONV && conv_cnt == adc_frontend_pkg::CONV_CNT_RESET && !byte_done)
    |=> (dout_out == (cmd.polarity_mode ? $past(comparator_in) : !$past(comparator_in))))
    else $error("first result bit coded wrong");

  AST_DESELECT_IDLE: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    cs_n_in |-> (bit_cnt == adc_frontend_pkg::BIT_CNT_IDLE && !strobe_out && !hold_out))
    else $error("framing alive while deselected");

  AST_VALID_PULSE: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    result_valid_out |=> !result_valid_out)
    else $error("result valid longer than one cycle");

endmodule

// [pkg/adc_frontend_pkg.sv]
// ============================================================
// Shared constants and types of the serial ADC front end
package adc_frontend_pkg;

  // ============================================================
  // Command byte layout, most significant bit first on the wire
  typedef struct packed {
    logic start;
    logic chan_sel_hi;
    logic chan_sel_mid;
    logic chan_sel_lo;
    logic polarity_mode;       // 1 unipolar, 0 bipolar
    logic input_config_mode;   // 1 single ended, 0 differential
    logic power_clock_mode_hi;
    logic power_clock_mode_lo;
  } cmd_t;

  localparam cmd_t CMD_RESET = 8'h00;
  localparam int CMD_LEN = 8;

  // Clock and power-down modes
  localparam logic [1:0] MODE_FULL_PD = 2'h0;
  localparam logic [1:0] MODE_FAST_PD = 2'h1;
  localparam logic [1:0] MODE_INT_CLK = 2'h2;
  localparam logic [1:0] MODE_EXT_CLK = 2'h3;

  // Channel codes, named by the positive input they pick
  localparam logic [2:0] SEL_CH0 = 3'h1;
  localparam logic [2:0] SEL_CH1 = 3'h5;
  localparam logic [2:0] SEL_CH2 = 3'h2;
  localparam logic [2:0] SEL_CH3 = 3'h6;

  // ============================================================
  // Multiplexer routing, one-hot per channel
  typedef struct packed {
    logic [3:0] pos;
    logic [3:0] neg;
    logic neg_common;
  } route_t;

  localparam route_t ROUTE_RESET = 9'h000;
  localparam logic [3:0] CH_NONE = 4'h0;
  localparam logic [3:0] CH0_ON = 4'h1;
  localparam logic [3:0] CH1_ON = 4'h2;
  localparam logic [3:0] CH2_ON = 4'h4;
  localparam logic [3:0] CH3_ON = 4'h8;

  // ============================================================
  // Framing counts on the serial clock
  localparam logic [3:0] BIT_CNT_IDLE = 4'h0;
  localparam logic [3:0] BIT_CNT_FIRST = 4'h1;
  localparam logic [3:0] BIT_CNT_TRACK = 4'h5;
  localparam logic [3:0] BIT_CNT_LAST = 4'h8;
  localparam logic [3:0] START_OK_CNT = 4'h5;
  localparam logic [3:0] CONV_CNT_RESET = 4'h0;
  localparam int RESULT_LEN = 12;

  // Link-side sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_TRACK = 4'h2,
    ST_CONV = 4'h4,
    ST_TAIL = 4'h8
  } link_state_t;

  // ============================================================
  // Longest conversion time watched on the core clock
  localparam int MAX_CONV_TIME_US = 120;
  localparam int CORE_CLK_MHZ = 125;
  localparam int MAX_CONV_CYCLES = MAX_CONV_TIME_US * CORE_CLK_MHZ;

endpackage

// [test/host_master.sv]
`timescale 1ns/1ps
// ============================================================
// Host serial master, clock mode zero, 64 ns link period
// Link rate scaled far up from the host's range for short runs
module host_master (
  input wire logic dout_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic din_out
);
  int falls = 0;

  // Link clock stands still low outside frames
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    din_out = 1'b0;
  end

  // Data set while clock is low, read back on the rising edge
  task automatic clock_bit(input logic b, output logic got);
    din_out = b;
    #32 sclk_out = 1'b1;
    got = dout_in;
    #32 sclk_out = 1'b0;
  endtask

  // Leading zeros, command, optional idle gap, two zero bytes
  task automatic frame(input logic [7:0] cmd, input int lead, input int gap, output logic [15:0] rx);
    logic unused;
    #3 cs_n_out = 1'b0;
    falls = 0;
    #32;
    repeat (lead) clock_bit(1'b0, unused);
    for (int i = 7; i >= 0; i--) begin
      clock_bit(cmd[i], unused);
      falls++;
    end
    // Gap stretches the conversion; the bench's 2400 ns gap runs past the droop limit
    #(gap);
    for (int i = 15; i >= 0; i--) begin
      clock_bit(1'b0, rx[i]);
      falls++;
    end
    #32 cs_n_out = 1'b1;
    #64;
  endtask
endmodule

// [test/testbench.sv]
`timescale 1ns/1ps
// ============================================================
// Self-checking bench of the serial ADC front end
module testbench;
  logic core_clk_in, rst_in, sclk_in, cs_n_in, din_in, comparator_in;
  logic dout_out, dout_oe_out, strobe_out, strobe_oe_out, track_out, hold_out;
  adc_frontend_pkg::route_t route_out, exp_route;
  logic [11:0] dac_trial_out, result_out, vin;
  adc_frontend_pkg::cmd_t result_cmd_out;
  logic result_valid_out, busy_out, overtime_out, ext;
  logic dout_keep = 1'b0;
  wire logic dout_wire;
  int n_mismatch = 0;
  int n_compared = 0;
  int n_valid = 0;
  // Listed codes first the rest probe the open-switch default
  logic [2:0] codes [8] = '{3'h1, 3'h5, 3'h2, 3'h6, 3'h0, 3'h3, 3'h4, 3'h7};

  adc_serial_control_byte_frontend #(.RESULT_BITS(12), .MAX_CONV_CYCLES(200)) dut (
    .core_clk_in, .rst_in, .sclk_in, .cs_n_in, .din_in, .comparator_in, .dout_out, .dout_oe_out,
    .strobe_out, .strobe_oe_out, .track_out, .hold_out, .route_out, .dac_trial_out, .result_cmd_out,
    .result_out, .result_valid_out, .busy_out, .overtime_out);

  host_master host (.dout_in(dout_wire), .sclk_out(sclk_in), .cs_n_out(cs_n_in), .din_out(din_in));

  // Released output shows a changed level, never the last bit
  assign dout_wire = dout_oe_out ? dout_out : ~dout_keep;
  // Ideal comparator: input at or above the trial code
  assign comparator_in = (vin >= dac_trial_out);

  always @(posedge core_clk_in) begin
    if (dout_oe_out) dout_keep <= dout_out;
    if (result_valid_out === 1'b1) n_valid++;
  end

  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Reference routing; unlisted codes open every channel switch
  function automatic adc_frontend_pkg::route_t route_of(input logic [7:0] c);
    logic [3:0] p, n;
    p = 4'h0;
    n = 4'h0;
    case (c[6:4])
      3'h1: begin p = 4'h1; n = 4'h2; end
      3'h5: begin p = 4'h2; n = 4'h1; end
      3'h2: begin p = 4'h4; n = 4'h8; end
      3'h6: begin p = 4'h8; n = 4'h4; end
      default: ;
    endcase
    if (c[2]) return {p, 4'h0, 1'b1};
    return {p, n, 1'b0};
  endfunction

  // ============================================================
  // Per-fall watch of the sampling stage and routing
  always @(negedge sclk_in) begin
    #4;
    if (!cs_n_in && host.falls > 0) begin
      chk({dout_oe_out, strobe_oe_out}, 2'h3);
      chk(track_out, host.falls >= 5 && host.falls < 8);
      chk(hold_out, ext && host.falls >= 8 && host.falls < 20);
      chk(strobe_out, ext && host.falls == 8);
      if (host.falls >= 8) chk(route_out, exp_route);
      if (host.falls >= 10 && host.falls < 20) chk(busy_out, ext);
    end
  end

  // One whole frame against the reference model
  task automatic run_frame(input logic [7:0] c, input int lead, input int gap);
    logic [15:0] rx;
    logic [11:0] res;
    int nv;
    ext = (c[1:0] == 2'h3);
    exp_route = route_of(c);
    vin = 12'($urandom);
    res = c[3] ? vin : vin ^ 12'h800;
    nv = n_valid;
    host.frame(c, lead, gap, rx);
    repeat (4) @(negedge core_clk_in);
    if (ext) begin
      chk(rx, {1'b0, res, 3'h0});
      chk(result_out, res);
      chk(result_cmd_out, c);
    end
    chk(n_valid - nv, ext);
    chk({route_out, dout_oe_out, strobe_oe_out, track_out, hold_out}, 0);
  endtask

  // ============================================================
  // Main sequence
  initial begin
    void'($urandom(32'h3cd37b80));
    rst_in = 1'b1;
    vin = 12'h000;
    ext = 1'b0;
    exp_route = '0;
    repeat (2) @(negedge core_clk_in);
    rst_in = 1'b0;
    repeat (3) @(negedge core_clk_in);
    chk({result_out, result_valid_out, busy_out, overtime_out}, 0);
    // Every channel code in both input modes, both polarities
    for (int i = 0; i < 8; i++) begin
      for (int se = 0; se < 2; se++) begin
        run_frame({1'b1, codes[i], 1'(i ^ se), 1'(se), 2'h3}, $urandom_range(3), 0);
      end
    end
    // Power-down and internal-clock modes convert nothing
    for (int m = 0; m < 3; m++) begin
      run_frame({1'b1, 3'h2, 2'h3, 2'(m)}, 1, 0);
    end
    // Slow host: idle gap after the command byte
    fork
      run_frame(8'hE7, 0, 2400);
      begin
        wait (host.falls == 8);
        #2000;
        chk(overtime_out, 1'b1);
      end
    join
    chk(overtime_out, 1'b0);
    end_of_test;
  end

  // Watchdog well past the expected run length
  initial begin
    #400000;
    n_mismatch++;
    end_of_test;
  end
endmodule
